// [rtl/ssx_exec.sv]
/*
 * Execution unit for sleep, the three subtracts, nibble swap and the
 * direction-register load, with accumulator, status, watchdog,
 * direction registers and a 128-byte file behind a wishbone slave.
 * Assumes the decoder runs on clk and presents one instruction per
 * cycle; the wishbone master is a classic single-cycle master.
 */
`timescale 1ns/10ps
`include "ssx_consts.svh"

// Function
// - sleep clears the power-down flag
// - sleep sets the timeout flag
// - sleep clears the watchdog counter and its prescaler; no operands
// - literal minus accumulator to accumulator; c and dc mean no borrow
// - file register minus accumulator; carry and half carry as no-borrow
// - destination selector 0 writes accumulator, 1 the file register
// - register minus accumulator minus inverted carry; updates c, dc, z
// - nibble swap exchanges register nibbles and leaves every flag alone
// - direction load copies accumulator to port a, b or c by operand 5-7
module ssx_exec #(
    parameter int PRESC_W = 8,
    parameter int WDT_W   = 8
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // decoded instruction
    input  wire ssx_pkg::ssx_instr_t instr,
    // wishbone slave
    input  wire ssx_pkg::ssx_wb_req_t wb_req,
    output logic [31:0]              wb_dat_o,
    output logic                     wb_ack_o,
    // core state
    output logic [7:0]               acc_o,
    output ssx_pkg::ssx_flags_t      flags_o,
    output logic [7:0]               dir_a_o,
    output logic [7:0]               dir_b_o,
    output logic [7:0]               dir_c_o,
    output logic [WDT_W-1:0]         watchdog_counter_o
);
    import ssx_pkg::*;

    // two's complement subtract a - b - ~cin: {carry, half carry, result}
    function automatic logic [9:0] ssx_sub(input logic [7:0] a,
                                          input logic [7:0] b,
                                          input logic       cin);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
        low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
        return {full[8], low[4], full[7:0]};
    endfunction

    logic [7:0]          acc_q, acc_d;
    ssx_flags_t          flags_q, flags_d;
    logic [7:0]          dir_a_q, dir_a_d;
    logic [7:0]          dir_b_q, dir_b_d;
    logic [7:0]          dir_c_q, dir_c_d;
    logic [PRESC_W-1:0]  presc_q, presc_d;
    logic [WDT_W-1:0]    wdt_q, wdt_d;
    logic                ack_q, ack_d;
    logic [31:0]         rdat_q, rdat_d;
    logic [7:0]          file_mem [0:127];
    logic                mem_we;
    logic [6:0]          mem_addr;
    logic [7:0]          mem_wdata;

    logic [7:0]          operand;
    logic [9:0]          sub_r;
    logic                bus_wr;
    logic                bus_file;
    logic [6:0]          bus_idx;

    assign operand  = file_mem[instr.f];
    assign bus_wr   = wb_req.cyc & wb_req.stb & wb_req.we & ack_q
                      & wb_req.sel[0];
    assign bus_file = wb_req.adr[11:9] == `SSX_FILE_BASE_HI;
    assign bus_idx  = wb_req.adr[8:2];

    // next state: bus writes first, instruction results override them
    always_comb begin
        acc_d     = acc_q;
        flags_d   = flags_q;
        dir_a_d   = dir_a_q;
        dir_b_d   = dir_b_q;
        dir_c_d   = dir_c_q;
        presc_d   = presc_q + PRESC_W'(1);
        wdt_d     = (&presc_q) ? wdt_q + WDT_W'(1) : wdt_q;
        mem_we    = 1'b0;
        mem_addr  = bus_idx;
        mem_wdata = wb_req.dat[7:0];
        sub_r     = 10'h000;
        // software writes to accumulator, c/dc/z, direction and file registers, low byte lane only
        if (bus_wr) begin
            if (bus_file) begin
                mem_we = 1'b1;
            end
            unique case (wb_req.adr)
                `SSX_OFF_ACC: acc_d = wb_req.dat[7:0];
                `SSX_OFF_STATUS: begin
                    flags_d.c               = wb_req.dat[`SSX_ST_C];
                    flags_d.half_carry_flag = wb_req.dat[`SSX_ST_DC];
                    flags_d.z               = wb_req.dat[`SSX_ST_Z];
                end
                `SSX_OFF_DIR_A: dir_a_d = wb_req.dat[7:0];
                `SSX_OFF_DIR_B: dir_b_d = wb_req.dat[7:0];
                `SSX_OFF_DIR_C: dir_c_d = wb_req.dat[7:0];
                default: ;
            endcase
        end
        // instruction execution
        unique case (instr.op)
            ssx_op_none: ;
            ssx_op_sleep: begin
                flags_d.power_down_flag = 1'b0;
                flags_d.timeout_flag    = 1'b1;
                wdt_d                   = WDT_W'(`SSX_WDT_CLEAR);
                presc_d                 = '0;
            end
            ssx_op_subtract_from_literal: begin
                sub_r = ssx_sub(instr.k, acc_q, 1'b1);
                acc_d = sub_r[7:0];
            end
            ssx_op_subtract_from_register: begin
                sub_r = ssx_sub(operand, acc_q, 1'b1);
            end
            ssx_op_subtract_with_borrow: begin
                sub_r = ssx_sub(operand, acc_q, flags_q.c);
            end
            ssx_op_nibble_swap: begin
                sub_r[7:0] = {operand[3:0], operand[7:4]};
            end
            ssx_op_direction_register_load: begin
                unique case (instr.f)
                    `SSX_DIR_SEL_A: dir_a_d = acc_q;
                    `SSX_DIR_SEL_B: dir_b_d = acc_q;
                    `SSX_DIR_SEL_C: dir_c_d = acc_q;
                    default: ;
                endcase
            end
            default: ;
        endcase
        // flags of all three subtracts
        if (instr.op == ssx_op_subtract_from_literal ||
            instr.op == ssx_op_subtract_from_register ||
            instr.op == ssx_op_subtract_with_borrow) begin
            flags_d.c               = sub_r[9];
            flags_d.half_carry_flag = sub_r[8];
            flags_d.z               = sub_r[7:0] == 8'h00;
        end
        // destination select for register-operand results
        if (instr.op == ssx_op_subtract_from_register ||
            instr.op == ssx_op_subtract_with_borrow ||
            instr.op == ssx_op_nibble_swap) begin
            if (instr.d) begin
                mem_we    = 1'b1;
                mem_addr  = instr.f;
                mem_wdata = sub_r[7:0];
            end else begin
                acc_d     = sub_r[7:0];
            end
        end
    end

    // bus answer: ack one cycle after the request, data with it
    always_comb begin
        ack_d  = wb_req.cyc & wb_req.stb & ~ack_q;
        rdat_d = 32'h0000_0000;
        if (ack_d && !wb_req.we) begin
            if (bus_file) begin
                rdat_d = {24'h00_0000, file_mem[bus_idx]};
            end else begin
                unique case (wb_req.adr)
                    `SSX_OFF_ACC:      rdat_d = {24'h00_0000, acc_q};
                    `SSX_OFF_STATUS:   rdat_d = {27'h000_0000, flags_q};
                    `SSX_OFF_WATCHDOG: rdat_d = 32'({presc_q, wdt_q});
                    `SSX_OFF_DIR_A:    rdat_d = {24'h00_0000, dir_a_q};
                    `SSX_OFF_DIR_B:    rdat_d = {24'h00_0000, dir_b_q};
                    `SSX_OFF_DIR_C:    rdat_d = {24'h00_0000, dir_c_q};
                    default:           rdat_d = 32'h0000_0000;
                endcase
            end
        end
    end

    // control and status registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_q   <= `SSX_RST_ACC;
            flags_q <= `SSX_RST_FLAGS;
            dir_a_q <= `SSX_RST_DIR;
            dir_b_q <= `SSX_RST_DIR;
            dir_c_q <= `SSX_RST_DIR;
            presc_q <= '0;
            wdt_q   <= '0;
            ack_q   <= 1'b0;
            rdat_q  <= 32'h0000_0000;
        end else begin
            acc_q   <= acc_d;
            flags_q <= flags_d;
            dir_a_q <= dir_a_d;
            dir_b_q <= dir_b_d;
            dir_c_q <= dir_c_d;
            presc_q <= presc_d;
            wdt_q   <= wdt_d;
            ack_q   <= ack_d;
            rdat_q  <= rdat_d;
        end
    end

    // file register array, single write port
    always_ff @(posedge clk) begin
        if (mem_we) begin
            file_mem[mem_addr] <= mem_wdata;
        end
    end

    // outputs straight from flip-flops
    assign wb_ack_o           = ack_q;
    assign wb_dat_o           = rdat_q;
    assign acc_o              = acc_q;
    assign flags_o            = flags_q;
    assign dir_a_o            = dir_a_q;
    assign dir_b_o            = dir_b_q;
    assign dir_c_o            = dir_c_q;
    assign watchdog_counter_o = wdt_q;

endmodule

// [rtl/ssx_consts.svh]
/*
 * Constants of the subtract/swap/sleep execution block: register
 * byte offsets, status field positions, reset values and the
 * direction-load operand codes.
 * Assumes inclusion by bare name from the block's design file.
 */
`ifndef SSX_CONSTS_SVH
`define SSX_CONSTS_SVH

// register byte offsets on the wishbone bus
`define SSX_OFF_ACC        12'h000
`define SSX_OFF_STATUS     12'h004
`define SSX_OFF_WATCHDOG   12'h008
`define SSX_OFF_DIR_A      12'h00c
`define SSX_OFF_DIR_B      12'h010
`define SSX_OFF_DIR_C      12'h014
// file registers: base + 4 * index, index 0 to 127
`define SSX_FILE_BASE_HI   3'h1

// status field positions
`define SSX_ST_C           0
`define SSX_ST_DC          1
`define SSX_ST_Z           2
`define SSX_ST_PD          3
`define SSX_ST_TO          4

// reset values and the watchdog clear value of sleep
`define SSX_RST_ACC        8'h00
`define SSX_RST_FLAGS      5'h18
`define SSX_RST_DIR        8'hff
`define SSX_WDT_CLEAR      8'h00

// direction-load operand codes
`define SSX_DIR_SEL_A      7'h05
`define SSX_DIR_SEL_B      7'h06
`define SSX_DIR_SEL_C      7'h07

`endif

// [rtl/ssx_pkg.sv]
/*
 * Types of the subtract/swap/sleep execution block: opcodes, the
 * decoded instruction, the status flags and the wishbone request.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ssx_pkg;

    // operations handed over by the instruction decoder
    typedef enum logic [2:0] {
        ssx_op_none,
        ssx_op_sleep,
        ssx_op_subtract_from_literal,
        ssx_op_subtract_from_register,
        ssx_op_subtract_with_borrow,
        ssx_op_nibble_swap,
        ssx_op_direction_register_load
    } ssx_op_t;

    // one decoded instruction, valid for one cycle
    typedef struct packed {
        ssx_op_t    op;
        logic [6:0] f;
        logic [7:0] k;
        logic       d;
    } ssx_instr_t;

    // status flags, carry in bit 0
    typedef struct packed {
        logic timeout_flag;
        logic power_down_flag;
        logic z;
        logic half_carry_flag;
        logic c;
    } ssx_flags_t;

    // classic wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [11:0] adr;
        logic [31:0] dat;
    } ssx_wb_req_t;

endpackage

// [verification/ssx_exec_chk.sv]
/* checker of the ssx execution unit
   assumes a bind onto ssx_exec, one clock domain */
`timescale 1ns/10ps
module ssx_exec_chk #(
    parameter int WDT_W = 8
) (
    // clock and reset
    input logic                 clk,
    input logic                 rst,
    // instruction and bus
    input ssx_pkg::ssx_instr_t  instr,
    input ssx_pkg::ssx_wb_req_t wb_req,
    input logic                 wb_ack_o,
    // core state
    input logic [7:0]           acc_o,
    input ssx_pkg::ssx_flags_t  flags_o,
    input logic [7:0]           dir_a_o,
    input logic [WDT_W-1:0]     watchdog_counter_o
);
    import ssx_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // sleep effects
    a_sleep_pd_low: assert property (
        instr.op == ssx_op_sleep |=> !flags_o.power_down_flag)
        else $error("sleep left power-down set");
    a_sleep_to_high: assert property (
        instr.op == ssx_op_sleep |=> flags_o.timeout_flag)
        else $error("sleep left timeout clear");
    a_sleep_wdt_zero: assert property (
        instr.op == ssx_op_sleep |=> watchdog_counter_o == '0)
        else $error("sleep left watchdog running");
    // literal subtract; zero flag of all three subtracts into the accumulator
    a_lit_result: assert property (
        instr.op == ssx_op_subtract_from_literal
        |=> acc_o == $past(instr.k) - $past(acc_o))
        else $error("literal subtract result wrong");
    a_lit_carries: assert property (
        instr.op == ssx_op_subtract_from_literal
        |=> {flags_o.c, flags_o.half_carry_flag} ==
            {$past(acc_o) <= $past(instr.k),
             $past(acc_o[3:0]) <= $past(instr.k[3:0])})
        else $error("literal subtract carries wrong");
    a_sub_zero: assert property (
        instr.op inside {ssx_op_subtract_from_literal,
            ssx_op_subtract_from_register,
            ssx_op_subtract_with_borrow} && !instr.d
        |=> flags_o.z == (acc_o == 8'h00))
        else $error("zero flag disagrees with result");
    // swap and direction load
    a_swap_keeps_flags: assert property (
        instr.op == ssx_op_nibble_swap && !(wb_req.cyc && wb_req.stb)
        |=> $stable(flags_o))
        else $error("swap changed a flag");
    a_dir_a_load: assert property (
        instr.op == ssx_op_direction_register_load && instr.f == 7'h05
        |=> dir_a_o == $past(acc_o))
        else $error("direction a not loaded");
    // bus answer
    a_ack_one_cycle: assert property (
        wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse after request");
endmodule

bind ssx_exec ssx_exec_chk #(.WDT_W(WDT_W)) chk_u (.clk, .rst, .instr,
    .wb_req, .wb_ack_o, .acc_o, .flags_o, .dir_a_o, .watchdog_counter_o);

// [verification/test_subtract_swap_sleep_exec.sv]
/* bench of the ssx execution unit: bus and instruction tasks
   assumes ssx_exec with its checker bound */
`timescale 1ns/10ps
module test_subtract_swap_sleep_exec;
    import ssx_pkg::*;
    logic        clk, rst, wb_ack_o;
    ssx_instr_t  instr;
    ssx_wb_req_t wb_req;
    ssx_flags_t  flags_o;
    logic [31:0] wb_dat_o, rd;
    logic [7:0]  acc_o, dir_a_o, dir_b_o, dir_c_o, wdt, a, k, r;
    logic [15:0] lit_case [5] = '{16'h0503, 16'h0305, 16'h0000,
                                  16'h1f20, 16'hff00};
    int          err_total = 0;
    int          checks_done = 0;

    ssx_exec #(.PRESC_W(2)) dut_u (.clk, .rst, .instr, .wb_req,
        .wb_dat_o, .wb_ack_o, .acc_o, .flags_o, .dir_a_o, .dir_b_o,
        .dir_c_o, .watchdog_counter_o(wdt));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // one classic wishbone cycle on lane 0
    task automatic bus(input logic we, input logic [11:0] adr,
                       input logic [7:0] dat);
        @(posedge clk);
        wb_req <= '{1'b1, 1'b1, we, 4'h1, adr, {24'h0, dat}};
        // wait for ack however long it takes; the hang guard ends a stall
        @(posedge clk);
        while (wb_ack_o !== 1'b1) begin
            @(posedge clk);
        end
        rd = wb_dat_o;
        wb_req <= '0;
    endtask

    // one instruction for one cycle
    task automatic run(input ssx_op_t op, input logic [6:0] f,
                       input logic [7:0] kk, input logic d);
        @(posedge clk);
        instr <= '{op, f, kk, d};
        @(posedge clk);
        instr <= '{ssx_op_none, 7'h00, 8'h00, 1'b0};
        #1;
    endtask

    // clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // hang guard
    initial begin
        #30000;
        err_total++;
        report_and_stop();
    end

    // test sequence
    initial begin
        rst = 1'b1;
        instr = '0;
        wb_req = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        bus(0, 12'h004, 8'h00);
        check(rd, 32'h18);
        bus(0, 12'h00c, 8'h00);
        check(rd, 32'hff);
        bus(0, 12'h100, 8'h00);
        check(rd, 32'h00);
        foreach (lit_case[i]) begin
            a = lit_case[i][15:8];
            k = lit_case[i][7:0];
            bus(1, 12'h000, a);
            run(ssx_op_subtract_from_literal, 7'h00, k, 1'b0);
            r = k - a;
            check(acc_o, r);
            check(flags_o[2:0],
                  {r == 8'h00, a[3:0] <= k[3:0], a <= k});
        end
        // register subtract to file, then to accumulator
        bus(1, 12'h3fc, 8'h20);
        bus(1, 12'h000, 8'h21);
        run(ssx_op_subtract_from_register, 7'h7f, 8'h00, 1'b1);
        check({acc_o, flags_o.c}, {8'h21, 1'b0});
        bus(0, 12'h3fc, 8'h00);
        check(rd, 32'hff);
        run(ssx_op_subtract_from_register, 7'h7f, 8'h00, 1'b0);
        check({acc_o, flags_o.c}, {8'hde, 1'b1});
        // borrow pending, then none
        bus(1, 12'h200, 8'h10);
        bus(1, 12'h000, 8'h0f);
        bus(1, 12'h004, 8'h00);
        run(ssx_op_subtract_with_borrow, 7'h00, 8'h00, 1'b0);
        check({acc_o, flags_o[2:0]}, {8'h00, 3'h5});
        run(ssx_op_subtract_with_borrow, 7'h00, 8'h00, 1'b1);
        check(flags_o[2:0], 3'h3);
        bus(0, 12'h200, 8'h00);
        check(rd, 32'h10);
        // nibble swap both ways
        bus(1, 12'h204, 8'ha5);
        run(ssx_op_nibble_swap, 7'h01, 8'h00, 1'b0);
        run(ssx_op_nibble_swap, 7'h01, 8'h00, 1'b1);
        check({acc_o, flags_o}, {8'h5a, 5'h1b});
        bus(0, 12'h204, 8'h00);
        check(rd, 32'h5a);
        // direction loads, operand 4 ignored
        bus(1, 12'h000, 8'h3c);
        run(ssx_op_direction_register_load, 7'h05, 8'h00, 1'b0);
        run(ssx_op_direction_register_load, 7'h06, 8'h00, 1'b0);
        run(ssx_op_direction_register_load, 7'h04, 8'h00, 1'b0);
        check({dir_a_o, dir_b_o, dir_c_o}, 24'h3c3cff);
        run(ssx_op_direction_register_load, 7'h07, 8'h00, 1'b0);
        check({dir_c_o, flags_o}, {8'h3c, 5'h1b});
        // sleep clears watchdog and prescaler
        repeat (20) @(posedge clk);
        run(ssx_op_sleep, 7'h00, 8'h00, 1'b0);
        check({wdt, flags_o[4:3]}, {8'h00, 2'h2});
        repeat (3) @(posedge clk);
        #1;
        check(wdt, 8'h00);
        @(posedge clk);
        #1;
        check(wdt, 8'h01);
        // watchdog readback: prescaler 1 and counter 1 when the read is taken
        bus(0, 12'h008, 8'h00);
        check(rd, 32'h101);
        report_and_stop();
    end
endmodule
